// >>> core/rie_pkg.sv
package rie_pkg;

	// register indices on the peripheral port
	localparam logic [3:0] RIE_IDX_STATUS = 4'h0;
	localparam logic [3:0] RIE_IDX_CLEAR = 4'h1;
	localparam logic [3:0] RIE_IDX_CTRL = 4'h2;
	localparam logic [3:0] RIE_IDX_SEL = 4'h3;
	localparam logic [3:0] RIE_IDX_TC_CHECK = 4'h4;
	localparam logic [3:0] RIE_IDX_AL_CHECK = 4'h5;

	// values after reset
	localparam logic [7:0] RIE_CTRL_RST = 8'h00;
	localparam logic [7:0] RIE_SEL_RST = 8'h00;
	localparam logic [7:0] RIE_CHECK_RST = 8'h00;
	localparam logic [4:0] RIE_FLAGS_RST = 5'h00;

	// selector field positions
	localparam int RIE_TSEL_LSB = 0;
	localparam int RIE_CSEL_LSB = 4;

	// selector codes
	localparam logic [1:0] RIE_TSEL_MIN = 2'h0;
	localparam logic [1:0] RIE_TSEL_HOUR = 2'h1;
	localparam logic [1:0] RIE_TSEL_MIDNIGHT = 2'h2;
	localparam logic [1:0] RIE_TSEL_NOON = 2'h3;
	localparam logic [1:0] RIE_CSEL_WEEK = 2'h0;
	localparam logic [1:0] RIE_CSEL_MONTH = 2'h1;
	localparam logic [1:0] RIE_CSEL_YEAR = 2'h2;

	// time and calendar field codes, also bit positions in the check
	localparam logic [2:0] RIE_FLD_SEC = 3'h0;
	localparam logic [2:0] RIE_FLD_MIN = 3'h1;
	localparam logic [2:0] RIE_FLD_HOUR = 3'h2;
	localparam logic [2:0] RIE_FLD_DAY = 3'h3;
	localparam logic [2:0] RIE_FLD_DATE = 3'h4;
	localparam logic [2:0] RIE_FLD_MONTH = 3'h5;
	localparam logic [2:0] RIE_FLD_YEAR = 3'h6;
	localparam logic [2:0] RIE_FLD_CENT = 3'h7;

	// alarm field codes
	localparam logic [2:0] RIE_AFLD_SEC = 3'h0;
	localparam logic [2:0] RIE_AFLD_MIN = 3'h1;
	localparam logic [2:0] RIE_AFLD_HOUR = 3'h2;
	localparam logic [2:0] RIE_AFLD_DATE = 3'h3;
	localparam logic [2:0] RIE_AFLD_MONTH = 3'h4;

	// binary limits of the bcd fields, and the two century codes in bcd
	localparam logic [7:0] RIE_MAX_SEC = 8'h3B;
	localparam logic [7:0] RIE_MAX_HOUR = 8'h17;
	localparam logic [7:0] RIE_MAX_DAY = 8'h07;
	localparam logic [7:0] RIE_MAX_MONTH = 8'h0C;
	localparam logic [7:0] RIE_MAX_YEAR = 8'h63;
	localparam logic [7:0] RIE_MAX_DATE = 8'h1F;
	localparam logic [7:0] RIE_MIN_ONE = 8'h01;
	localparam logic [7:0] RIE_CENT_LO = 8'h19;
	localparam logic [7:0] RIE_CENT_HI = 8'h20;

	typedef struct packed {
		logic cal;
		logic tim;
		logic sec;
		logic alarm;
		logic ack;
	} rie_flags_t;

	typedef struct packed {
		logic wr;
		logic [2:0] field;
		logic [7:0] data;
	} rie_fwr_t;

	typedef struct packed {
		logic [7:0] century;
		logic [7:0] year;
		logic [7:0] month;
	} rie_cal_t;

	typedef struct packed {
		logic minute;
		logic hour;
		logic midnight;
		logic noon;
		logic sunday;
		logic month_first;
		logic year_first;
	} rie_tick_t;

endpackage : rie_pkg

// >>> core/rie_entry_check.sv
`timescale 1ns/1ps
module rie_entry_check import rie_pkg::*; (
	// field write and held calendar
	input wire logic alarm_in,
	input wire rie_fwr_t fwr_in,
	input wire rie_cal_t cal_in,
	// verdict
	output logic valid_out
);

	function automatic logic [7:0] bcd_num(input logic [7:0] b);
		bcd_num = 8'({4'h0, b[7:4]} * 8'h0A + {4'h0, b[3:0]});
	endfunction : bcd_num

	function automatic logic in_range(input logic [7:0] b,
		input logic [7:0] lo, input logic [7:0] hi);
		logic ok;
		ok = (b[7:4] <= 4'h9) && (b[3:0] <= 4'h9);
		in_range = ok && (bcd_num(b) >= lo) && (bcd_num(b) <= hi);
	endfunction : in_range

	logic leap;
	logic [7:0] days;
	logic [7:0] mnum;
	logic [7:0] ad;

	always_comb begin
		// bcd year divisible by four; 1900 is the only century miss in range
		leap = (!cal_in.year[4] && (cal_in.year[3:0] == 4'h0 ||
			cal_in.year[3:0] == 4'h4 || cal_in.year[3:0] == 4'h8)) ||
			(cal_in.year[4] && (cal_in.year[3:0] == 4'h2 ||
			cal_in.year[3:0] == 4'h6));
		if (cal_in.year == 8'h00 && cal_in.century == RIE_CENT_LO) begin
			leap = 1'b0;
		end
		mnum = bcd_num(cal_in.month);
		// stale or bad month falls back to 31 days
		case (mnum)
			8'h02: days = leap ? 8'h1D : 8'h1C;
			8'h04, 8'h06, 8'h09, 8'h0B: days = 8'h1E;
			default: days = RIE_MAX_DATE;
		endcase
		// alarm enable bit 7 is not part of the value
		ad = {1'b0, fwr_in.data[6:0]};
		valid_out = 1'b0;
		if (alarm_in) begin
			case (fwr_in.field)
				RIE_AFLD_SEC, RIE_AFLD_MIN:
					valid_out = in_range(ad, 8'h00, RIE_MAX_SEC);
				RIE_AFLD_HOUR: valid_out = in_range(ad, 8'h00, RIE_MAX_HOUR);
				RIE_AFLD_DATE:
					valid_out = in_range(ad, RIE_MIN_ONE, RIE_MAX_DATE);
				RIE_AFLD_MONTH:
					valid_out = in_range(ad, RIE_MIN_ONE, RIE_MAX_MONTH);
				default: valid_out = 1'b0;
			endcase
		end else begin
			case (fwr_in.field)
				RIE_FLD_SEC, RIE_FLD_MIN:
					valid_out = in_range(fwr_in.data, 8'h00, RIE_MAX_SEC);
				RIE_FLD_HOUR:
					valid_out = in_range(fwr_in.data, 8'h00, RIE_MAX_HOUR);
				RIE_FLD_DAY:
					valid_out = in_range(fwr_in.data, RIE_MIN_ONE, RIE_MAX_DAY);
				RIE_FLD_DATE:
					valid_out = in_range(fwr_in.data, RIE_MIN_ONE, days);
				RIE_FLD_MONTH:
					valid_out = in_range(fwr_in.data, RIE_MIN_ONE, RIE_MAX_MONTH);
				RIE_FLD_YEAR:
					valid_out = in_range(fwr_in.data, 8'h00, RIE_MAX_YEAR);
				RIE_FLD_CENT:
					valid_out = fwr_in.data == RIE_CENT_LO ||
						fwr_in.data == RIE_CENT_HI;
				default: valid_out = 1'b0;
			endcase
		end
	end

endmodule : rie_entry_check

// >>> core/rie_irq_entry.sv
`timescale 1ns/1ps
module rie_irq_entry import rie_pkg::*; #(
	parameter int ADDR_W = 4
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	// status events from counters and comparators
	input wire logic update_grant_in,
	input wire logic alarm_match_in,
	input wire logic one_hz_in,
	input wire rie_tick_t tick_in,
	// field write strobes and held calendar
	input wire rie_fwr_t tc_fwr_in,
	input wire rie_fwr_t al_fwr_in,
	input wire rie_cal_t cal_in,
	// interrupt and status
	output logic irq_out,
	output rie_flags_t status_out
);

	if (ADDR_W < 3 || ADDR_W > 4) begin : g_chk
		$error("ADDR_W must be 3 or 4");
	end

	logic [7:0] ctrl_r, ctrl_nxt;
	logic [7:0] sel_r, sel_nxt;
	rie_flags_t stat_r, stat_nxt;
	logic [7:0] tc_chk_r, tc_chk_nxt;
	logic [7:0] al_chk_r, al_chk_nxt;
	logic irq_r, irq_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic seen_r, seen_nxt;

	logic tc_ok;
	logic al_ok;
	logic tim_hit;
	logic cal_hit;
	logic [3:0] addr;
	logic [4:0] set_v;
	logic [4:0] clr_v;
	logic [1:0] tsel;
	logic [1:0] csel;

	rie_entry_check u_tc_check (
		.alarm_in(1'b0),
		.fwr_in(tc_fwr_in),
		.cal_in(cal_in),
		.valid_out(tc_ok)
	);

	rie_entry_check u_al_check (
		.alarm_in(1'b1),
		.fwr_in(al_fwr_in),
		.cal_in(cal_in),
		.valid_out(al_ok)
	);

	// control and select registers
	always_comb begin
		addr = 4'(reg_addr_in);
		ctrl_nxt = ctrl_r;
		sel_nxt = sel_r;
		seen_nxt = 1'b1;
		if (reg_wr_in && addr == RIE_IDX_CTRL) begin
			ctrl_nxt = reg_wdata_in;
		end
		if (reg_wr_in && addr == RIE_IDX_SEL) begin
			sel_nxt = reg_wdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_r <= RIE_CTRL_RST;
			sel_r <= RIE_SEL_RST;
			seen_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			sel_r <= sel_nxt;
			seen_r <= seen_nxt;
		end
	end

	// status flags and interrupt level
	always_comb begin
		tsel = sel_r[RIE_TSEL_LSB +: 2];
		csel = sel_r[RIE_CSEL_LSB +: 2];
		case (tsel)
			RIE_TSEL_MIN: tim_hit = tick_in.minute;
			RIE_TSEL_HOUR: tim_hit = tick_in.hour;
			RIE_TSEL_MIDNIGHT: tim_hit = tick_in.midnight;
			RIE_TSEL_NOON: tim_hit = tick_in.noon;
			default: tim_hit = 1'b0;
		endcase
		// reserved code raises nothing
		case (csel)
			RIE_CSEL_WEEK: cal_hit = tick_in.sunday;
			RIE_CSEL_MONTH: cal_hit = tick_in.month_first;
			RIE_CSEL_YEAR: cal_hit = tick_in.year_first;
			default: cal_hit = 1'b0;
		endcase
		set_v = {cal_hit, tim_hit, one_hz_in, alarm_match_in,
			update_grant_in};
		clr_v = (reg_wr_in && addr == RIE_IDX_CLEAR) ?
			reg_wdata_in[4:0] : 5'h00;
		// a set in the clearing cycle wins, so no event is lost
		stat_nxt = rie_flags_t'(set_v | (stat_r & ~clr_v));
		// bit 0 gates only update grant; 1..4 the other flags
		irq_nxt = |(stat_nxt & ctrl_nxt[4:0]);
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			stat_r <= rie_flags_t'(RIE_FLAGS_RST);
			irq_r <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			irq_r <= irq_nxt;
		end
	end

	// sticky entry checks; only a write to a field moves its bit
	always_comb begin
		tc_chk_nxt = tc_chk_r;
		if (tc_fwr_in.wr) begin
			tc_chk_nxt[tc_fwr_in.field] = !tc_ok;
		end
		al_chk_nxt = al_chk_r;
		if (al_fwr_in.wr && al_fwr_in.field <= RIE_AFLD_MONTH) begin
			al_chk_nxt[al_fwr_in.field] = !al_ok;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tc_chk_r <= RIE_CHECK_RST;
			al_chk_r <= RIE_CHECK_RST;
		end else begin
			tc_chk_r <= tc_chk_nxt;
			al_chk_r <= al_chk_nxt;
		end
	end

	// read data is registered, one cycle behind the index
	always_comb begin
		case (addr)
			RIE_IDX_STATUS: rdata_nxt = {3'h0, stat_r};
			RIE_IDX_CTRL: rdata_nxt = ctrl_r;
			RIE_IDX_SEL: rdata_nxt = sel_r;
			RIE_IDX_TC_CHECK: rdata_nxt = tc_chk_r;
			RIE_IDX_AL_CHECK: rdata_nxt = al_chk_r;
			default: rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign irq_out = irq_r;
	assign reg_rdata_out = rdata_r;
	assign status_out = stat_r;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);

	chk_irq_level: assert property (
		irq_out == |(stat_r & ctrl_r[4:0]))
		else $error("interrupt level differs from enabled flags");

	chk_irq_tick_raise: assert property (
		(one_hz_in && ctrl_nxt[2]) |=> irq_out)
		else $error("enabled tick did not raise interrupt");

	chk_ack_only_gate: assert property (
		(!ctrl_r[0] && ((stat_r & ctrl_r[4:0]) == 5'h00)) |-> !irq_out)
		else $error("update grant leaked through disabled gate");

	chk_reset_zero: assert property (
		!seen_r |-> (ctrl_r == 8'h00 && sel_r == 8'h00))
		else $error("control or select not zero after reset");

	chk_hour_select: assert property (
		(tsel == RIE_TSEL_HOUR && tick_in.hour) |=> stat_r.tim)
		else $error("hour event did not set time flag");

	chk_cal_reserved: assert property (
		(csel == 2'h3 && !stat_r.cal && !(reg_wr_in && addr == RIE_IDX_SEL))
		|=> !stat_r.cal)
		else $error("reserved calendar code raised flag");

	chk_tc_bad_set: assert property (
		(tc_fwr_in.wr && !tc_ok) |=> tc_chk_r[$past(tc_fwr_in.field)])
		else $error("bad time entry not flagged");

	chk_tc_hold: assert property (
		!tc_fwr_in.wr |=> $stable(tc_chk_r))
		else $error("time check changed without a write");

	chk_al_verdict: assert property (
		(al_fwr_in.wr && al_fwr_in.field <= RIE_AFLD_MONTH) |=>
		al_chk_r[$past(al_fwr_in.field)] == !$past(al_ok))
		else $error("alarm check does not match verdict");

	chk_feb_29: assert property (
		(tc_fwr_in.wr && tc_fwr_in.field == RIE_FLD_DATE &&
		tc_fwr_in.data == 8'h29 && cal_in.month == 8'h02 &&
		cal_in.year == 8'h98 && cal_in.century == 8'h19)
		|=> tc_chk_r[4])
		else $error("feb 29 in 1998 accepted");

	chk_clear_flag: assert property (
		(reg_wr_in && addr == RIE_IDX_CLEAR && reg_wdata_in[2] && !one_hz_in)
		|=> !stat_r.sec ##1 (!stat_r.sec || $past(one_hz_in)))
		else $error("clear bit did not clear tick flag");

	chk_time_sticky: assert property (
		(stat_r.tim && !(reg_wr_in && addr == RIE_IDX_CLEAR &&
		reg_wdata_in[3])) |=> stat_r.tim)
		else $error("time flag dropped without clear");

	chk_irq_ack_raise: assert property (
		(update_grant_in && ctrl_nxt[0]) |=> irq_out)
		else $error("enabled update grant did not raise interrupt");

	chk_irq_alarm_raise: assert property (
		(alarm_match_in && ctrl_nxt[1]) |=> irq_out)
		else $error("enabled alarm did not raise interrupt");

	chk_irq_time_raise: assert property (
		(tim_hit && ctrl_nxt[3]) |=> irq_out)
		else $error("enabled time event did not raise interrupt");

	chk_irq_cal_raise: assert property (
		(cal_hit && ctrl_nxt[4]) |=> irq_out)
		else $error("enabled calendar event did not raise interrupt");

	chk_alarm_own_gate: assert property (
		(stat_r.alarm && ctrl_r[1:0] == 2'h1 && !stat_r.ack &&
		(stat_r[4:2] & ctrl_r[4:2]) == 3'h0) |-> !irq_out)
		else $error("bit 0 enable let the alarm flag through");

	chk_ack_gate_on: assert property (
		(stat_r.ack && ctrl_r[0]) |-> irq_out)
		else $error("enabled update grant flag gave no interrupt");

	chk_min_select: assert property (
		(tsel == RIE_TSEL_MIN && tick_in.minute) |=> stat_r.tim)
		else $error("minute event did not set time flag");

	chk_midnight_select: assert property (
		(tsel == RIE_TSEL_MIDNIGHT && tick_in.midnight) |=> stat_r.tim)
		else $error("midnight event did not set time flag");

	chk_noon_select: assert property (
		(tsel == RIE_TSEL_NOON && tick_in.noon) |=> stat_r.tim)
		else $error("noon event did not set time flag");

	chk_week_select: assert property (
		(csel == RIE_CSEL_WEEK && tick_in.sunday) |=> stat_r.cal)
		else $error("weekly event did not set calendar flag");

	chk_month_select: assert property (
		(csel == RIE_CSEL_MONTH && tick_in.month_first) |=> stat_r.cal)
		else $error("monthly event did not set calendar flag");

	chk_year_select: assert property (
		(csel == RIE_CSEL_YEAR && tick_in.year_first) |=> stat_r.cal)
		else $error("yearly event did not set calendar flag");

	chk_tc_good_clear: assert property (
		(tc_fwr_in.wr && tc_ok) |=> !tc_chk_r[$past(tc_fwr_in.field)])
		else $error("good time entry left its flag set");

	chk_al_hold: assert property (
		!al_fwr_in.wr |=> $stable(al_chk_r))
		else $error("alarm check changed without a write");

	chk_al_top_zero: assert property (
		al_chk_r[7:5] == 3'h0)
		else $error("unused alarm check bits not zero");

	chk_feb_29_leap: assert property (
		(tc_fwr_in.wr && tc_fwr_in.field == RIE_FLD_DATE &&
		tc_fwr_in.data == 8'h29 && cal_in.month == 8'h02 &&
		cal_in.year == 8'h00 && cal_in.century == 8'h20)
		|=> !tc_chk_r[4])
		else $error("feb 29 in 2000 refused");

	chk_cal_sticky: assert property (
		(stat_r.cal && !(reg_wr_in && addr == RIE_IDX_CLEAR &&
		reg_wdata_in[4])) |=> stat_r.cal)
		else $error("calendar flag dropped without clear");

	chk_tick_no_spur: assert property (
		(!stat_r.sec && !one_hz_in) |=> !stat_r.sec)
		else $error("tick flag set without a tick");

	chk_clear_all: assert property (
		(reg_wr_in && addr == RIE_IDX_CLEAR && reg_wdata_in[4:0] == 5'h1F
		&& set_v == 5'h00) |=> (stat_r == 5'h00 && !irq_out))
		else $error("full clear left a flag or interrupt");

	chk_irq_hold: assert property (
		(irq_out && !(reg_wr_in && (addr == RIE_IDX_CLEAR ||
		addr == RIE_IDX_CTRL))) |=> irq_out)
		else $error("interrupt dropped without clear or disable");

endmodule : rie_irq_entry

// >>> sim/rie_core_model.sv
`timescale 1ns/1ps
module rie_core_model (
	// clock
	input wire logic clk_in,
	// register port toward the block
	output logic [3:0] addr_out,
	output logic wr_out,
	output logic [7:0] wdata_out,
	output logic rd_out
);
	initial begin
		addr_out = 4'h0;
		wr_out = 1'b0;
		wdata_out = 8'h00;
		rd_out = 1'b0;
	end
	// one-cycle strobe; data garbled after release so stale bytes show
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wr_out <= 1'b1;
		wdata_out <= d;
		@(posedge clk_in);
		wr_out <= 1'b0;
		wdata_out <= ~d;
	endtask : wr
	// read marker only; data comes back one edge later
	task automatic rd(input logic [3:0] a);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
	endtask : rd
endmodule : rie_core_model

// >>> sim/rtc_irq_and_entry_check_test.sv
`timescale 1ns/1ps
module rtc_irq_and_entry_check_test import rie_pkg::*; ;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [3:0] addr;
	logic wr, rd, irq, rd_d = 1'b0;
	logic [7:0] wdata, rdata, tcx = 8'h00, alx = 8'h00;
	logic ug = 1'b0, am = 1'b0, oh = 1'b0;
	rie_tick_t tick = '0;
	rie_fwr_t tc_fwr = '0, al_fwr = '0;
	rie_cal_t cal = {8'h19, 8'h98, 8'h02};
	rie_flags_t st;
	logic [13:0] exp_q[$];
	logic [13:0] e;
	int err_count = 0, check_count = 0, cyc = 0;
	// al, field, data, bad as hex nibbles
	logic [19:0] tbl [0:24] = '{20'h00601, 20'h015A1, 20'h00590, 20'h02241,
		20'h03001, 20'h03070, 20'h05131, 20'h069A1, 20'h07211, 20'h07200,
		20'h01000, 20'h04291, 20'h02230, 20'h05120, 20'h06990, 20'h04290,
		20'h04301, 20'h10601, 20'h10D90, 20'h11601, 20'h12241, 20'h13321,
		20'h14001, 20'h15FF1, 20'h14120};

	initial begin
		forever #12.5 clk_in = ~clk_in;
	end

	rie_core_model u_rie_core_model (.clk_in(clk_in), .addr_out(addr),
		.wr_out(wr), .wdata_out(wdata), .rd_out(rd));

	rie_irq_entry u_rie_irq_entry (.clk_in(clk_in), .rstn_in(rstn_in),
		.reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .update_grant_in(ug), .alarm_match_in(am),
		.one_hz_in(oh), .tick_in(tick), .tc_fwr_in(tc_fwr),
		.al_fwr_in(al_fwr), .cal_in(cal), .irq_out(irq), .status_out(st));

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict

	// read data is judged one edge after the read is taken
	always @(posedge clk_in) begin
		rd_d <= rd;
		cyc <= cyc + 1;
		if (rd_d) begin
			e = exp_q.pop_front();
			check_count++;
			if ({st, irq, rdata} !== e) begin
				err_count++;
				$display("FAIL t=%0t got %h exp %h", $time,
					{st, irq, rdata}, e);
			end
		end
		if (cyc == 3000) begin
			err_count++;
			print_verdict();
		end
	end

	task automatic expect_rd(input logic [3:0] a, input logic [7:0] d,
		input logic q);
		// status pins hold only what a status read shows, else nothing
		exp_q.push_back({a == RIE_IDX_STATUS ? d[4:0] : 5'h00, q, d});
		u_rie_core_model.rd(a);
	endtask : expect_rd

	task automatic pulse(input int s, input rie_tick_t t);
		@(posedge clk_in);
		ug <= (s == 0);
		am <= (s == 1);
		oh <= (s == 2);
		tick <= t;
		@(posedge clk_in);
		ug <= 1'b0;
		am <= 1'b0;
		oh <= 1'b0;
		tick <= '0;
	endtask : pulse

	// write one field, then read back the running sticky image
	task automatic chk_fw(input logic [19:0] t);
		@(posedge clk_in);
		if (t[16]) al_fwr <= {1'b1, t[14:12], t[11:4]};
		else tc_fwr <= {1'b1, t[14:12], t[11:4]};
		@(posedge clk_in);
		al_fwr <= {1'b0, t[14:12], ~t[11:4]};
		tc_fwr <= {1'b0, t[14:12], ~t[11:4]};
		if (!t[16]) tcx[t[14:12]] = t[0];
		else if (t[14:12] < 3'h5) alx[t[14:12]] = t[0];
		expect_rd(t[16] ? RIE_IDX_AL_CHECK : RIE_IDX_TC_CHECK,
			t[16] ? alx : tcx, 1'b0);
	endtask : chk_fw

	initial begin
		logic [7:0] v;
		void'($urandom(32'h65a29661));
		repeat (3) @(posedge clk_in);
		rstn_in <= 1'b1;
		for (int i = 0; i < 8; i++) expect_rd(i[3:0], 8'h00, 1'b0);
		v = $urandom();
		u_rie_core_model.wr(RIE_IDX_SEL, v);
		expect_rd(RIE_IDX_SEL, v, 1'b0);
		u_rie_core_model.wr(RIE_IDX_CTRL, {v[7:5], 5'h00});
		expect_rd(RIE_IDX_CTRL, {v[7:5], 5'h00}, 1'b0);
		u_rie_core_model.wr(RIE_IDX_TC_CHECK, 8'hFF);
		expect_rd(RIE_IDX_TC_CHECK, 8'h00, 1'b0);
		u_rie_core_model.wr(RIE_IDX_SEL, 8'h00);
		$display("test registers done");
		// other enables on must not leak onto this flag
		for (int i = 0; i < 5; i++) begin
			pulse(i, i == 3 ? 7'h40 : (i == 4 ? 7'h04 : 7'h00));
			u_rie_core_model.wr(RIE_IDX_CTRL, ~(8'h01 << i));
			expect_rd(RIE_IDX_STATUS, 8'h01 << i, 1'b0);
			u_rie_core_model.wr(RIE_IDX_CTRL, 8'h01 << i);
			expect_rd(RIE_IDX_STATUS, 8'h01 << i, 1'b1);
			u_rie_core_model.wr(RIE_IDX_CLEAR, 8'h00);
			expect_rd(RIE_IDX_STATUS, 8'h01 << i, 1'b1);
			u_rie_core_model.wr(RIE_IDX_CLEAR, 8'h01 << i);
			expect_rd(RIE_IDX_STATUS, 8'h00, 1'b0);
		end
		$display("test sources done");
		u_rie_core_model.wr(RIE_IDX_CTRL, 8'h18);
		for (int c = 0; c < 4; c++) begin
			u_rie_core_model.wr(RIE_IDX_SEL, {2'h0, c[1:0], 2'h0, c[1:0]});
			for (int b = 0; b < 7; b++) begin
				pulse(3, 7'h01 << b);
				v = {3'h0, b == 2 - c && c < 3, b == 6 - c, 3'h0};
				expect_rd(RIE_IDX_STATUS, v, |v);
				u_rie_core_model.wr(RIE_IDX_CLEAR, 8'h1F);
			end
		end
		$display("test selectors done");
		for (int k = 0; k < 25; k++) begin
			if (k == 15) cal <= {8'h20, 8'h00, 8'h02};
			chk_fw(tbl[k]);
		end
		$display("test entry checks done");
		repeat (3) @(posedge clk_in);
		print_verdict();
	end
endmodule : rtc_irq_and_entry_check_test
